// ### rtl/ssm_cfg.svh
// Offsets, field positions, reset values and codes of the sync and mode block.
// Assumes inclusion by bare name from files that import ssm_pkg.
`ifndef SSM_CFG_SVH
`define SSM_CFG_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SSM_OFS_MODE 8'h00
`define SSM_OFS_WIDTH 8'h04
`define SSM_OFS_LINES 8'h08

// ----------------------------------------
// Reset values and writable masks
// ----------------------------------------
`define SSM_RST_MODE 32'h00000000
`define SSM_RST_WIDTH 32'h00000000
`define SSM_RST_LINES 32'h00000000
`define SSM_WMASK_MODE 32'h00013FFF
`define SSM_WMASK_WIDTH 32'h0FFF0FFF
`define SSM_WMASK_LINES 32'hFFFFFFFF

// ----------------------------------------
// Field positions of sync_mode_setup
// ----------------------------------------
`define SSM_B_DIR 0
`define SSM_B_FLDDIR 1
`define SSM_B_FRMPOL 2
`define SSM_B_LINPOL 3
`define SSM_B_FIELD_FLAG_POLARITY 4
`define SSM_B_EXTSEL 5
`define SSM_B_INVERT 6
`define SSM_B_SCAN 7
`define SSM_B_WID_LO 8
`define SSM_B_WID_HI 10
`define SSM_B_PACK 11
`define SSM_B_FMT_LO 12
`define SSM_B_FMT_HI 13
`define SSM_B_FSTAT 15
`define SSM_B_ENABLE 16

// ----------------------------------------
// Field positions of width and period words
// ----------------------------------------
`define SSM_LW_LO 16
`define SSM_LW_HI 27
`define SSM_FW_LO 0
`define SSM_FW_HI 11
`define SSM_LP_LO 16
`define SSM_LP_HI 31
`define SSM_HL_LO 0
`define SSM_HL_HI 15

// ----------------------------------------
// Codes
// ----------------------------------------
`define SSM_FMT_RAW 2'h0
`define SSM_WID_8BIT 3'h7
`define SSM_RESP_OKAY 2'h0
`define SSM_RESP_SLVERR 2'h2

`endif

// ### rtl/ssm_pkg.sv
// Types shared by the sync and mode block.
// Assumes nothing of its surroundings.
package ssm_pkg;

	// ----------------------------------------
	// Configuration carried across domains
	// ----------------------------------------
	typedef struct packed {
		logic sync_generator_enable;
		logic [1:0] input_format;
		logic pack_byte_pixels;
		logic [2:0] raw_sample_width;
		logic field_scan_mode;
		logic sample_invert;
		logic external_write_gate_select;
		logic field_flag_polarity;
		logic line_sync_polarity;
		logic frame_sync_polarity;
		logic field_flag_direction;
		logic sync_direction;
		logic [11:0] line_sync_width;
		logic [11:0] frame_sync_width;
		logic [15:0] line_period;
		logic [15:0] half_lines_per_field;
	} ssm_cfg_t;

	// ----------------------------------------
	// Timing settings latched at frame start
	// ----------------------------------------
	typedef struct packed {
		logic [11:0] line_sync_width;
		logic [11:0] frame_sync_width;
		logic [15:0] line_period;
		logic [15:0] half_lines_per_field;
	} ssm_geom_t;

endpackage

// ### rtl/ssm_sync2.sv
// Two-flop synchroniser for levels, with synchronous active-low reset.
// Assumes d_in comes from another domain or a pin.
`timescale 1ns/1ps
module ssm_sync2 #(
	parameter int W = 1
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	logic [W-1:0] meta_reg, meta_next, q_reg, q_next;

	always_comb begin
		meta_next = rstn_in ? d_in : '0;
		q_next = rstn_in ? meta_reg : '0;
	end

	always_ff @(posedge clk_in) begin
		meta_reg <= meta_next;
		q_reg <= q_next;
	end

	assign q_out = q_reg;
endmodule

// ### rtl/ssm_timing.sv
// Line and frame timing generator on the pixel clock.
// Assumes pin levels are already synchronised and polarity-corrected.
`timescale 1ns/1ps
module ssm_timing
	import ssm_pkg::*;
(
	input wire logic pclk_in,
	input wire logic rstn_in,
	input wire logic enable_in,
	input wire logic drive_in,
	input wire ssm_geom_t geom_in,
	input wire logic line_pin_in,
	input wire logic frame_pin_in,
	output logic line_act_out,
	output logic frame_act_out,
	output logic frame_evt_out
);
	logic [15:0] pix_reg, pix_next, line_reg, line_next;
	logic lprev_reg, lprev_next, fprev_reg, fprev_next;
	logic lact_reg, lact_next, fact_reg, fact_next, evt_reg, evt_next;
	logic [16:0] frame_len;
	logic [15:0] last_line;
	logic pix_end, line_end, line_rise, frame_rise;

	always_comb begin
		frame_len = ({1'b0, geom_in.half_lines_per_field} + 17'h00001) >> 1;
		last_line = (frame_len == 17'h00000) ? 16'h0000 : 16'(frame_len - 17'h00001);
		pix_end = (pix_reg >= geom_in.line_period);
		line_end = (line_reg >= last_line);
		line_rise = line_pin_in & ~lprev_reg;
		frame_rise = frame_pin_in & ~fprev_reg;
		lprev_next = rstn_in & line_pin_in;
		fprev_next = rstn_in & frame_pin_in;
		pix_next = pix_reg;
		line_next = line_reg;
		evt_next = 1'b0;
		lact_next = 1'b0;
		fact_next = 1'b0;
		if (!rstn_in || !enable_in) begin
			pix_next = 16'h0000;
			line_next = 16'h0000;
		end else if (drive_in) begin
			pix_next = pix_end ? 16'h0000 : 16'(pix_reg + 16'h0001);
			if (pix_end) begin
				line_next = line_end ? 16'h0000 : 16'(line_reg + 16'h0001);
			end
			evt_next = pix_end && line_end;
			lact_next = ({4'h0, geom_in.line_sync_width} >= pix_next);
			fact_next = ({4'h0, geom_in.frame_sync_width} >= line_next);
		end else begin
			// Counters follow the incoming edges so a switch to drive stays coherent
			pix_next = line_rise ? 16'h0000 : 16'(pix_reg + 16'h0001);
			if (frame_rise) begin
				line_next = 16'h0000;
			end else if (line_rise) begin
				line_next = 16'(line_reg + 16'h0001);
			end
			evt_next = frame_rise;
			lact_next = line_pin_in;
			fact_next = frame_pin_in;
		end
	end

	always_ff @(posedge pclk_in) begin
		pix_reg <= pix_next;
		line_reg <= line_next;
		lprev_reg <= lprev_next;
		fprev_reg <= fprev_next;
		lact_reg <= lact_next;
		fact_reg <= fact_next;
		evt_reg <= evt_next;
	end

	assign line_act_out = lact_reg;
	assign frame_act_out = fact_reg;
	assign frame_evt_out = evt_reg;
endmodule

// ### rtl/ssm_top.sv
// Sync and mode block: AXI4-Lite registers, sync pins and sample path.
// Assumes an AXI4-Lite master on clk_in and a sensor on its own pixel clock.
// Behaviour
// - Pack bit selects 16 or 8 bits/pixel
// - Width code 0..6 is 16..10, 7 is 8
// - External write gate used only when selected
// - Driven line sync lasts width plus one
// - Line sync width ignored for input sync
// - Driven frame sync lasts width plus one lines
// - Frame sync width ignored for input sync
// - Width settings take effect at frame start
// - Direction bit selects input or driven sync
// - Enable runs timing and sample writes, off holds both idle
// - Driven line period is setting plus one
// - Frame period is half lines plus one, halved
`timescale 1ns/1ps
`include "ssm_cfg.svh"
module ssm_top
	import ssm_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter int PIX_W = 16
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [ADDR_W-1:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic pclk_in,
	input wire logic [PIX_W-1:0] pix_data_in,
	input wire logic line_sync_in,
	output logic line_sync_out,
	output logic line_sync_oe_out,
	input wire logic frame_sync_in,
	output logic frame_sync_out,
	output logic frame_sync_oe_out,
	input wire logic field_in,
	output logic field_out,
	output logic field_oe_out,
	input wire logic ext_write_en_in,
	output logic sdram_wr_valid_out,
	output logic [15:0] sdram_wr_data_out
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] merge_strb(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] strb, input logic [31:0] wmask);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & wmask;
		return (old_v & ~m) | (new_v & m);
	endfunction

	function automatic logic [4:0] sample_bits(input logic [1:0] fmt, input logic [2:0] code);
		logic [4:0] w;
		w = 5'h10;
		if (fmt == `SSM_FMT_RAW) begin
			w = (code == `SSM_WID_8BIT) ? 5'h08 : 5'(5'h10 - {2'h0, code});
		end
		return w;
	endfunction

	function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
		return (a[ADDR_W-1:2] == ADDR_W'(ofs) >> 2);
	endfunction

	// ----------------------------------------
	// Register bus, clk_in domain
	// ----------------------------------------
	logic aw_got_reg, aw_got_next, w_got_reg, w_got_next;
	logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
	logic [31:0] w_data_reg, w_data_next;
	logic [3:0] w_strb_reg, w_strb_next;
	logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
	logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [31:0] mode_reg, mode_next, width_reg, width_next, lines_reg, lines_next;
	logic do_write, do_read, fstat_s;
	logic [31:0] mode_rd;

	assign s_axi_awready_out = !aw_got_reg && !bvalid_reg;
	assign s_axi_wready_out = !w_got_reg && !bvalid_reg;
	assign s_axi_arready_out = !rvalid_reg;
	assign do_write = aw_got_reg && w_got_reg && !bvalid_reg;
	assign do_read = s_axi_arvalid_in && !rvalid_reg;

	always_comb begin
		mode_rd = mode_reg;
		mode_rd[`SSM_B_FSTAT] = fstat_s;
		aw_got_next = aw_got_reg;
		aw_addr_next = aw_addr_reg;
		w_got_next = w_got_reg;
		w_data_next = w_data_reg;
		w_strb_next = w_strb_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg;
		rresp_next = rresp_reg;
		rdata_next = rdata_reg;
		mode_next = mode_reg;
		width_next = width_reg;
		lines_next = lines_reg;
		if (s_axi_awvalid_in && s_axi_awready_out) begin
			aw_got_next = 1'b1;
			aw_addr_next = s_axi_awaddr_in;
		end
		if (s_axi_wvalid_in && s_axi_wready_out) begin
			w_got_next = 1'b1;
			w_data_next = s_axi_wdata_in;
			w_strb_next = s_axi_wstrb_in;
		end
		if (do_write) begin
			aw_got_next = 1'b0;
			w_got_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = `SSM_RESP_OKAY;
			if (addr_hit(aw_addr_reg, `SSM_OFS_MODE)) begin
				mode_next = merge_strb(mode_reg, w_data_reg, w_strb_reg, `SSM_WMASK_MODE);
			end else if (addr_hit(aw_addr_reg, `SSM_OFS_WIDTH)) begin
				width_next = merge_strb(width_reg, w_data_reg, w_strb_reg, `SSM_WMASK_WIDTH);
			end else if (addr_hit(aw_addr_reg, `SSM_OFS_LINES)) begin
				lines_next = merge_strb(lines_reg, w_data_reg, w_strb_reg, `SSM_WMASK_LINES);
			end else begin
				bresp_next = `SSM_RESP_SLVERR;
			end
		end else if (bvalid_reg && s_axi_bready_in) begin
			bvalid_next = 1'b0;
		end
		if (do_read) begin
			rvalid_next = 1'b1;
			rresp_next = `SSM_RESP_OKAY;
			if (addr_hit(s_axi_araddr_in, `SSM_OFS_MODE)) begin
				rdata_next = mode_rd;
			end else if (addr_hit(s_axi_araddr_in, `SSM_OFS_WIDTH)) begin
				rdata_next = width_reg;
			end else if (addr_hit(s_axi_araddr_in, `SSM_OFS_LINES)) begin
				rdata_next = lines_reg;
			end else begin
				rdata_next = 32'h00000000;
				rresp_next = `SSM_RESP_SLVERR;
			end
		end else if (rvalid_reg && s_axi_rready_in) begin
			rvalid_next = 1'b0;
		end
		if (!rstn_in) begin
			aw_got_next = 1'b0;
			w_got_next = 1'b0;
			bvalid_next = 1'b0;
			rvalid_next = 1'b0;
			bresp_next = `SSM_RESP_OKAY;
			rresp_next = `SSM_RESP_OKAY;
			rdata_next = 32'h00000000;
			mode_next = `SSM_RST_MODE;
			width_next = `SSM_RST_WIDTH;
			lines_next = `SSM_RST_LINES;
		end
	end

	always_ff @(posedge clk_in) begin
		aw_got_reg <= aw_got_next;
		aw_addr_reg <= aw_addr_next;
		w_got_reg <= w_got_next;
		w_data_reg <= w_data_next;
		w_strb_reg <= w_strb_next;
		bvalid_reg <= bvalid_next;
		bresp_reg <= bresp_next;
		rvalid_reg <= rvalid_next;
		rresp_reg <= rresp_next;
		rdata_reg <= rdata_next;
		mode_reg <= mode_next;
		width_reg <= width_next;
		lines_reg <= lines_next;
	end

	assign s_axi_bvalid_out = bvalid_reg;
	assign s_axi_bresp_out = bresp_reg;
	assign s_axi_rvalid_out = rvalid_reg;
	assign s_axi_rresp_out = rresp_reg;
	assign s_axi_rdata_out = rdata_reg;

	// ----------------------------------------
	// Configuration handshake toward pixel clock
	// ----------------------------------------
	// Hold stays frozen while a toggle is in flight, so the far side samples a stable word
	ssm_cfg_t cfg_now, hold_reg, hold_next;
	logic dirty_reg, dirty_next, req_reg, req_next, ack_s, launch;

	always_comb begin
		cfg_now.sync_generator_enable = mode_reg[`SSM_B_ENABLE];
		cfg_now.input_format = mode_reg[`SSM_B_FMT_HI:`SSM_B_FMT_LO];
		cfg_now.pack_byte_pixels = mode_reg[`SSM_B_PACK];
		cfg_now.raw_sample_width = mode_reg[`SSM_B_WID_HI:`SSM_B_WID_LO];
		cfg_now.field_scan_mode = mode_reg[`SSM_B_SCAN];
		cfg_now.sample_invert = mode_reg[`SSM_B_INVERT];
		cfg_now.external_write_gate_select = mode_reg[`SSM_B_EXTSEL];
		cfg_now.field_flag_polarity = mode_reg[`SSM_B_FIELD_FLAG_POLARITY];
		cfg_now.line_sync_polarity = mode_reg[`SSM_B_LINPOL];
		cfg_now.frame_sync_polarity = mode_reg[`SSM_B_FRMPOL];
		cfg_now.field_flag_direction = mode_reg[`SSM_B_FLDDIR];
		cfg_now.sync_direction = mode_reg[`SSM_B_DIR];
		cfg_now.line_sync_width = width_reg[`SSM_LW_HI:`SSM_LW_LO];
		cfg_now.frame_sync_width = width_reg[`SSM_FW_HI:`SSM_FW_LO];
		cfg_now.line_period = lines_reg[`SSM_LP_HI:`SSM_LP_LO];
		cfg_now.half_lines_per_field = lines_reg[`SSM_HL_HI:`SSM_HL_LO];
		launch = dirty_reg && (req_reg == ack_s);
		hold_next = launch ? cfg_now : hold_reg;
		req_next = launch ? ~req_reg : req_reg;
		// A write in the launch cycle keeps dirty set
		dirty_next = do_write ? 1'b1 : (launch ? 1'b0 : dirty_reg);
		if (!rstn_in) begin
			hold_next = '0;
			req_next = 1'b0;
			dirty_next = 1'b1;
		end
	end

	always_ff @(posedge clk_in) begin
		hold_reg <= hold_next;
		req_reg <= req_next;
		dirty_reg <= dirty_next;
	end

	// ----------------------------------------
	// Pixel clock domain
	// ----------------------------------------
	logic prst_n, req_s, line_s, frame_s, field_s, we_s;
	logic [PIX_W-1:0] data_s;
	logic ack_reg, ack_next, field_reg, field_next, phase_reg, phase_next, lprev_reg, lprev_next;
	logic lpin_reg, lpin_next, fpin_reg, fpin_next, dpin_reg, dpin_next;
	logic wv_reg, wv_next;
	logic [7:0] lo_reg, lo_next, pbyte;
	logic [15:0] wd_reg, wd_next, sample;
	logic [4:0] wbits;
	ssm_cfg_t stg_reg, stg_next;
	ssm_geom_t geom_reg, geom_next;
	logic line_act, frame_act, frame_evt, gate;

	ssm_sync2 #(.W(1)) u_prst (.clk_in(pclk_in), .rstn_in(1'b1), .d_in(rstn_in), .q_out(prst_n));
	ssm_sync2 #(.W(PIX_W + 5)) u_pins (
		.clk_in(pclk_in),
		.rstn_in(prst_n),
		.d_in({pix_data_in, line_sync_in, frame_sync_in, field_in, ext_write_en_in, req_reg}),
		.q_out({data_s, line_s, frame_s, field_s, we_s, req_s})
	);
	ssm_sync2 #(.W(2)) u_back (
		.clk_in(clk_in),
		.rstn_in(rstn_in),
		.d_in({ack_reg, field_reg}),
		.q_out({ack_s, fstat_s})
	);

	ssm_timing u_timing (
		.pclk_in(pclk_in),
		.rstn_in(prst_n),
		.enable_in(stg_reg.sync_generator_enable),
		.drive_in(stg_reg.sync_direction),
		.geom_in(geom_reg),
		.line_pin_in(line_s ^ stg_reg.line_sync_polarity),
		.frame_pin_in(frame_s ^ stg_reg.frame_sync_polarity),
		.line_act_out(line_act),
		.frame_act_out(frame_act),
		.frame_evt_out(frame_evt)
	);

	always_comb begin
		ack_next = req_s;
		stg_next = (req_s != ack_reg) ? hold_reg : stg_reg;
		geom_next = geom_reg;
		// Timing words load only at frame start, or freely while the generator is off
		if (frame_evt || !stg_reg.sync_generator_enable) begin
			geom_next = {stg_reg.line_sync_width, stg_reg.frame_sync_width,
				stg_reg.line_period, stg_reg.half_lines_per_field};
		end
		field_next = field_reg;
		if (stg_reg.field_flag_direction) begin
			if (!stg_reg.field_scan_mode) begin
				field_next = 1'b0;
			end else if (frame_evt) begin
				field_next = ~field_reg;
			end
		end else begin
			field_next = field_s ^ stg_reg.field_flag_polarity;
		end
		dpin_next = stg_reg.sync_direction;
		lpin_next = line_act ^ stg_reg.line_sync_polarity;
		fpin_next = frame_act ^ stg_reg.frame_sync_polarity;
		lprev_next = line_act;
		wbits = sample_bits(stg_reg.input_format, stg_reg.raw_sample_width);
		sample = (stg_reg.sample_invert ? ~16'(data_s) : 16'(data_s)) & (16'hFFFF >> (5'h10 - wbits));
		pbyte = 8'(sample >> (wbits - 5'h08));
		gate = stg_reg.sync_generator_enable && (!stg_reg.external_write_gate_select || we_s);
		phase_next = phase_reg;
		lo_next = lo_reg;
		wv_next = 1'b0;
		wd_next = wd_reg;
		if (line_act && !lprev_reg) begin
			phase_next = 1'b0;
		end else if (gate) begin
			if (!stg_reg.pack_byte_pixels) begin
				wv_next = 1'b1;
				wd_next = sample;
			end else if (!phase_reg) begin
				phase_next = 1'b1;
				lo_next = pbyte;
			end else begin
				phase_next = 1'b0;
				wv_next = 1'b1;
				wd_next = {pbyte, lo_reg};
			end
		end
		if (!prst_n) begin
			ack_next = 1'b0;
			stg_next = '0;
			geom_next = '0;
			field_next = 1'b0;
			dpin_next = 1'b0;
			lpin_next = 1'b0;
			fpin_next = 1'b0;
			lprev_next = 1'b0;
			phase_next = 1'b0;
			lo_next = 8'h00;
			wv_next = 1'b0;
			wd_next = 16'h0000;
		end
	end

	always_ff @(posedge pclk_in) begin
		ack_reg <= ack_next;
		stg_reg <= stg_next;
		geom_reg <= geom_next;
		field_reg <= field_next;
		dpin_reg <= dpin_next;
		lpin_reg <= lpin_next;
		fpin_reg <= fpin_next;
		lprev_reg <= lprev_next;
		phase_reg <= phase_next;
		lo_reg <= lo_next;
		wv_reg <= wv_next;
		wd_reg <= wd_next;
	end

	assign line_sync_out = lpin_reg;
	assign frame_sync_out = fpin_reg;
	assign line_sync_oe_out = dpin_reg;
	assign frame_sync_oe_out = dpin_reg;
	assign field_out = field_reg ^ stg_reg.field_flag_polarity;
	assign field_oe_out = stg_reg.field_flag_direction;
	assign sdram_wr_valid_out = wv_reg;
	assign sdram_wr_data_out = wd_reg;
endmodule

// ### verification/ssm_props.sv
// Port checks for the sync and mode block.
// Assumes binding into ssm_top; both domains share rstn_in.
`timescale 1ns/1ps
module ssm_props (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic s_axi_awvalid_in,
	input wire logic s_axi_awready_out,
	input wire logic s_axi_wvalid_in,
	input wire logic s_axi_wready_out,
	input wire logic [1:0] s_axi_bresp_out,
	input wire logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic s_axi_arvalid_in,
	input wire logic s_axi_arready_out,
	input wire logic [31:0] s_axi_rdata_out,
	input wire logic [1:0] s_axi_rresp_out,
	input wire logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic pclk_in,
	input wire logic line_sync_oe_out,
	input wire logic frame_sync_oe_out
);
	// ----------------
	// Bus and pins
	// ----------------
	bhold_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
		else $error("write answer not held");
	rhold_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
		else $error("read answer not held");
	wans_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out |=> ##1 s_axi_bvalid_out)
		else $error("write answer late");
	rans_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
		else $error("read answer late");
	wblock_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
		else $error("write taken during answer");
	rblock_a: assert property (@(posedge clk_in) disable iff (!rstn_in) s_axi_rvalid_out |-> !s_axi_arready_out)
		else $error("read taken during answer");
	bresp_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		$rose(s_axi_bvalid_out) |-> s_axi_bresp_out == 2'h0 || s_axi_bresp_out == 2'h2)
		else $error("bad write response code");
	sync_oe_a: assert property (@(posedge pclk_in) disable iff (!rstn_in)
		line_sync_oe_out == frame_sync_oe_out)
		else $error("sync enables differ");
endmodule

bind ssm_top ssm_props u_props (.clk_in(clk_in), .rstn_in(rstn_in), .s_axi_awvalid_in(s_axi_awvalid_in),
	.s_axi_awready_out(s_axi_awready_out), .s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out),
	.s_axi_bresp_out(s_axi_bresp_out), .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
	.s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out), .s_axi_rdata_out(s_axi_rdata_out),
	.s_axi_rresp_out(s_axi_rresp_out), .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in),
	.pclk_in(pclk_in), .line_sync_oe_out(line_sync_oe_out), .frame_sync_oe_out(frame_sync_oe_out));

// ### verification/ssm_sensor.sv
// Behavioural image source: 16-pixel lines, 4-line frames.
// Assumes the bench resolves sync wires against the device's enables.
`timescale 1ns/1ps
module ssm_sensor (
	input wire logic pclk_in,
	input wire logic run_in,
	input wire logic [15:0] pix_in,
	output logic [15:0] pix_out = 16'h0000,
	output logic line_out = 1'b0,
	output logic frame_out = 1'b0,
	output logic field_out = 1'b0
);
	logic [3:0] px = 4'h0;
	logic [1:0] ln = 2'h0;
	always @(posedge pclk_in) begin
		if (run_in) begin
			px <= px + 4'h1;
			if (px == 4'hF)
				ln <= ln + 2'h1;
			if (px == 4'hF && ln == 2'h3)
				field_out <= ~field_out;
			pix_out <= pix_in;
			line_out <= (px < 4'h2);
			frame_out <= (ln == 2'h0);
		end else begin
			// Idle data and sync lines wander so stale levels never pass for data; the field line holds
			pix_out <= ~pix_out;
			line_out <= ~line_out;
			frame_out <= ~frame_out;
		end
	end
endmodule

// ### verification/ssm_top_tb_top.sv
// Self-checking bench for the sync and mode block.
// Assumes ssm_top and the ssm_sensor model.
`timescale 1ns/1ps
module ssm_top_tb_top;
	logic clk = 1'b0, pclk = 1'b0, rstn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h00000000;
	logic ext_we = 1'b0, run = 1'b0;
	logic [15:0] pix_val = 16'h5A5A;
	logic awready, wready, bvalid, arready, rvalid, lso, lsoe, fso, fsoe, fo, foe, wr_v, s_line, s_frame, s_fld;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [15:0] pix, wr_d;
	int err_total = 0, checks = 0;
	always #12.5 clk = ~clk;
	always #80 pclk = ~pclk;
	ssm_sensor u_sen (.pclk_in(pclk), .run_in(run), .pix_in(pix_val), .pix_out(pix), .line_out(s_line),
		.frame_out(s_frame), .field_out(s_fld));
	ssm_top dut (.clk_in(clk), .rstn_in(rstn), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
		.s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
		.s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
		.s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
		.pclk_in(pclk), .pix_data_in(pix), .line_sync_in(lsoe ? lso : s_line), .line_sync_out(lso),
		.line_sync_oe_out(lsoe), .frame_sync_in(fsoe ? fso : s_frame), .frame_sync_out(fso),
		.frame_sync_oe_out(fsoe), .field_in(foe ? fo : s_fld), .field_out(fo), .field_oe_out(foe),
		.ext_write_en_in(ext_we), .sdram_wr_valid_out(wr_v), .sdram_wr_data_out(wr_d));
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	// Ready sampled at the low phase: it cannot move before the next rising edge
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ta, tw, hb, done;
		logic [1:0] br;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		done = 1'b0;
		while (!done) begin
			@(negedge clk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			hb = bvalid;
			done = bvalid && bready;
			br = bresp;
			@(posedge clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (hb && !done) bready <= 1'b1;
		end
		bready <= 1'b0;
		chk("bresp", {30'h0, br}, {30'h0, er});
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
		logic ta, hr, done;
		logic [31:0] rd;
		logic [1:0] rr;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		done = 1'b0;
		while (!done) begin
			@(negedge clk);
			ta = arvalid && arready;
			hr = rvalid;
			done = rvalid && rready;
			rd = rdata;
			rr = rresp;
			@(posedge clk);
			if (ta) arvalid <= 1'b0;
			if (hr && !done) rready <= 1'b1;
		end
		rready <= 1'b0;
		chk("rdata", rd & m, e);
		chk("rresp", {30'h0, rr}, {30'h0, er});
	endtask
	function automatic logic sg(input logic f);
		return f ? fso : lso;
	endfunction
	task automatic meas(input logic f, input logic act, input int ehi, input int eper);
		int hi, per;
		while (sg(f) === act) @(negedge pclk);
		while (sg(f) !== act) @(negedge pclk);
		hi = 0;
		while (sg(f) === act) begin
			hi++;
			@(negedge pclk);
		end
		per = hi;
		while (sg(f) !== act) begin
			per++;
			@(negedge pclk);
		end
		chk("pulse", hi, ehi);
		chk("period", per, eper);
	endtask
	task automatic wcap(input logic [15:0] e);
		repeat (40) @(negedge pclk);
		while (wr_v !== 1'b1) @(negedge pclk);
		chk("wrdata", {16'h0, wr_d}, {16'h0, e});
	endtask
	task automatic gate(input logic s, input logic we, input logic e);
		int n;
		axw(8'h00, s ? 32'h00010020 : 32'h00010000, 2'h0);
		ext_we <= we;
		repeat (40) @(negedge pclk);
		n = 0;
		repeat (64) begin
			@(negedge pclk);
			if (wr_v === 1'b1) n++;
		end
		chk("gated", n > 0, e);
	endtask
	task automatic t_regs;
		rdchk(8'h00, 32'hFFFF7FFF, 32'h0, 2'h0);
		rdchk(8'h04, 32'hFFFFFFFF, 32'h0, 2'h0);
		axw(8'h00, 32'hFFFFFFFF, 2'h0);
		rdchk(8'h00, 32'hFFFF7FFF, 32'h00013FFF, 2'h0);
		axw(8'h04, 32'hFFFFFFFF, 2'h0);
		rdchk(8'h04, 32'hFFFFFFFF, 32'h0FFF0FFF, 2'h0);
		axw(8'h0C, 32'h00000001, 2'h2);
		rdchk(8'h0C, 32'hFFFFFFFF, 32'h0, 2'h2);
		axw(8'h00, 32'h00000000, 2'h0);
		$display("t_regs done");
	endtask
	task automatic t_drive;
		axw(8'h04, 32'h00020000, 2'h0);
		axw(8'h08, 32'h000F0007, 2'h0);
		axw(8'h00, 32'h00010001, 2'h0);
		repeat (40) @(negedge pclk);
		chk("oe", {lsoe, fsoe}, 2'b11);
		meas(1'b0, 1'b1, 3, 16);
		meas(1'b1, 1'b1, 16, 64);
		axw(8'h00, 32'h0001000D, 2'h0);
		repeat (40) @(negedge pclk);
		meas(1'b0, 1'b0, 3, 16);
		axw(8'h04, 32'h00050000, 2'h0);
		repeat (200) @(negedge pclk);
		meas(1'b0, 1'b0, 6, 16);
		$display("t_drive done");
	endtask
	task automatic t_field;
		int n;
		logic p;
		axw(8'h00, 32'h00010083, 2'h0);
		repeat (40) @(negedge pclk);
		n = 0;
		p = fo;
		repeat (128) begin
			@(negedge pclk);
			if (fo !== p) n++;
			p = fo;
		end
		chk("toggles", n, 2);
		axw(8'h00, 32'h00010013, 2'h0);
		repeat (40) @(negedge pclk);
		chk("field_flag_polarity", fo, 1'b1);
		$display("t_field done");
	endtask
	task automatic t_input;
		run <= 1'b1;
		for (int c = 0; c < 8; c++) begin
			axw(8'h00, 32'h00010042 | (c << 8), 2'h0);
			wcap(~16'h5A5A & ((17'h1 << (c == 7 ? 8 : 16 - c)) - 17'h1));
		end
		chk("oe", {lsoe, fsoe, foe}, 3'b001);
		pix_val <= 16'h12C3;
		axw(8'h00, 32'h00010800, 2'h0);
		wcap(16'h1212);
		axw(8'h00, 32'h00011700, 2'h0);
		wcap(16'h12C3);
		gate(1'b1, 1'b0, 1'b0);
		gate(1'b1, 1'b1, 1'b1);
		gate(1'b0, 1'b0, 1'b1);
		$display("t_input done");
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clk);
		// Pixel side needs a few pixel clocks of reset too
		repeat (4) @(posedge pclk);
		@(posedge clk);
		rstn <= 1'b1;
		t_regs;
		t_drive;
		t_field;
		t_input;
		tally_and_finish;
	end
	initial begin
		#2000000;
		err_total++;
		tally_and_finish;
	end
endmodule
